//--- bench/e1bo_core_monitor.sv
// Port-level checker for the E1 backplane offset block
`timescale 1ns/1ps
`default_nettype none
module e1bo_core_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic tx_bit_valid,
	input wire logic tx_bit_data,
	input wire logic tx_bit_sig,
	input wire logic [6:0] tx_bit_slot,
	input wire logic [2:0] tx_bit_pos,
	input wire logic tx_frame_start,
	input wire logic rx_line_take,
	input wire logic rx_serial_data_out,
	input wire logic rx_serial_data_oe,
	input wire logic rx_signaling_oe,
	input wire logic rx_frame_pulse_oe,
	input wire logic rx_clock_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_ack_one_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_pulse_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_frame_start_zero: assert property (tx_frame_start |-> tx_bit_valid &&
		tx_bit_slot == 7'h00 && tx_bit_pos == 3'h0)
		else $error("frame start off position zero");
	a_tx_bit_spacing: assert property (tx_bit_valid |=> !tx_bit_valid [*3])
		else $error("tx bits too close");
	a_tx_bits_hold: assert property (!tx_bit_valid |->
		$stable(tx_bit_data) && $stable(tx_bit_sig))
		else $error("tx bits changed without valid");
	a_oe_pair: assert property (rx_serial_data_oe == rx_signaling_oe)
		else $error("data and signaling enables differ");
	a_master_oe_pair: assert property (rx_clock_oe == rx_frame_pulse_oe)
		else $error("clock and pulse enables differ");
	a_rx_change_take: assert property ($changed(rx_serial_data_out) |-> rx_line_take)
		else $error("rx data changed without take");
	c_frame: cover property (tx_frame_start);
	c_take: cover property (rx_line_take);
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind e1bo_core e1bo_core_monitor e1bo_core_monitor_inst (.core_clk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .tx_bit_valid, .tx_bit_data,
	.tx_bit_sig, .tx_bit_slot, .tx_bit_pos, .tx_frame_start, .rx_line_take,
	.rx_serial_data_out, .rx_serial_data_oe, .rx_signaling_oe,
	.rx_frame_pulse_oe, .rx_clock_oe);
`default_nettype wire

//--- bench/e1bo_sys_model.sv
// Backplane side source of link clock, frame pulse and serial bits
`timescale 1ns/1ps
`default_nettype none
module e1bo_sys_model (
	input wire logic run,
	output logic link_clk,
	output logic frame_pulse,
	output logic data_bit,
	output logic sig_bit
);
	logic [7:0] cnt_q = 8'h00;
	initial begin
		link_clk = 1'b0;
		forever begin
			#400;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end
	always @(posedge link_clk) begin
		cnt_q <= cnt_q + 8'h01;
	end
	assign data_bit = run ? cnt_q[1] : ~cnt_q[1];
	assign sig_bit = run ? cnt_q[3] : ~cnt_q[3];
	assign frame_pulse = run && cnt_q == 8'h00;
endmodule
`default_nettype wire

//--- bench/tb_e1bo_core.sv
// Self-checking bench for the E1 backplane offset block
`timescale 1ns/1ps
`default_nettype none
module tb_e1bo_core;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic run = 1'b0;
	logic line_half_tick = 1'b0;
	logic line_frame_start = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [2:0] hcnt = 3'h0;
	logic [7:0] q;
	int miscompares = 0;
	int n_tests = 0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, tx_bit_data, tx_bit_sig, tx_frame_start;
	wire rx_serial_data_oe, rx_frame_pulse_out, rx_clock_oe;
	wire tclk, tfp, tdat, tsig;
	e1bo_sys_model e1bo_sys_model_inst (.run(run), .link_clk(tclk),
		.frame_pulse(tfp), .data_bit(tdat), .sig_bit(tsig));
	e1bo_core e1bo_core_inst (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.tx_system_clock(tclk), .tx_frame_pulse(tfp), .tx_serial_data_in(tdat),
		.tx_signaling_in(tsig), .tx_bit_valid(), .tx_bit_data, .tx_bit_sig,
		.tx_bit_slot(), .tx_bit_pos(), .tx_frame_start, .rx_system_clock(tclk),
		.rx_frame_pulse_in(tfp), .line_half_tick, .line_frame_start,
		.line_crc_mf_start(1'b0), .line_sig_mf_start(1'b0), .rx_line_data(tdat),
		.rx_line_sig(1'b0), .rx_line_slot(), .rx_line_bit(), .rx_line_take(),
		.rx_serial_data_out(), .rx_serial_data_oe, .rx_signaling_out(),
		.rx_signaling_oe(), .rx_frame_pulse_out, .rx_frame_pulse_oe(),
		.rx_clock_out(), .rx_clock_oe);
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		hcnt <= hcnt + 3'h1;
		line_half_tick <= hcnt == 3'h3;
	end
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wb(input logic w, input logic [9:0] i, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge core_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		q = wb_dat_o[7:0];
		if (k == 20) miscompares++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	task t_regs;
		logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h0D, 8'h01, 8'h00, 8'h00};
		logic [7:0] mk [6] = '{8'h7F, 8'h0F, 8'h0F, 8'h01, 8'h1E, 8'h7F};
		for (int n = 0; n < 6; n++) begin
			wb(1'b0, 10'h044 + 10'(n), 8'h00);
			chk("reset value", q, rv[n]);
			wb(1'b1, 10'h044 + 10'(n), 8'hFF);
			wb(1'b0, 10'h044 + 10'(n), 8'h00);
			chk("writable bits", q, mk[n]);
		end
		wb(1'b1, 10'h050, 8'hFF);
		wb(1'b0, 10'h050, 8'h00);
		chk("unmapped", q, 8'h00);
	endtask
	task t_txoff(input logic [7:0] sl, input logic [7:0] bo,
		input logic ed, input logic es);
		int k;
		wb(1'b1, 10'h044, sl);
		wb(1'b1, 10'h045, bo);
		repeat (2) begin
			k = 0;
			do begin
				@(posedge core_clk);
				k++;
			end while (tx_frame_start !== 1'b1 && k < 3000);
		end
		chk("tx data at frame start", tx_bit_data, ed);
		chk("tx sig at frame start", tx_bit_sig, es);
	endtask
	task t_rx;
		wb(1'b1, 10'h046, 8'h0C);
		repeat (2) @(posedge core_clk);
		chk("rx data enable", rx_serial_data_oe, 8'h01);
		wb(1'b1, 10'h046, 8'h0D);
		repeat (2) @(posedge core_clk);
		chk("rx data released", rx_serial_data_oe, 8'h00);
		line_frame_start <= 1'b1;
		@(posedge core_clk);
		line_frame_start <= 1'b0;
		wb(1'b1, 10'h048, 8'h10);
		wb(1'b1, 10'h047, 8'h00);
		repeat (100) @(posedge core_clk);
		chk("master clock enable", rx_clock_oe, 8'h01);
		chk("inverted idle pulse", rx_frame_pulse_out, 8'h01);
		wb(1'b1, 10'h048, 8'h00);
		repeat (40) @(posedge core_clk);
		chk("idle pulse", rx_frame_pulse_out, 8'h00);
		wb(1'b1, 10'h047, 8'h01);
		repeat (2) @(posedge core_clk);
		chk("slave clock released", rx_clock_oe, 8'h00);
	endtask
	task final_report;
		if (miscompares == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		run <= 1'b1;
		t_regs;
		// Offset 3 slots 5 bits, slot field masked to five bits
		t_txoff(8'h23, 8'h05, 1'b0, 1'b1);
		t_txoff(8'h00, 8'h02, 1'b1, 1'b0);
		// Double rate, second edge: bit n taken at link count 2n+1
		wb(1'b1, 10'h060, 8'h01);
		t_txoff(8'h00, 8'h0C, 1'b0, 1'b1);
		wb(1'b1, 10'h060, 8'h00);
		wb(1'b0, 10'h061, 8'h00);
		chk("link status", q, 8'h03);
		t_rx;
		final_report;
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		final_report;
	end
endmodule
`default_nettype wire

//--- hw/e1bo_core.v
// E1 backplane timeslot/bit offset, edge selection and frame pulse logic
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "e1bo_defs.vh"

module e1bo_core (
	input wire core_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [11:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire tx_system_clock,
	input wire tx_frame_pulse,
	input wire tx_serial_data_in,
	input wire tx_signaling_in,
	output reg tx_bit_valid,
	output reg tx_bit_data,
	output reg tx_bit_sig,
	output reg [6:0] tx_bit_slot,
	output reg [2:0] tx_bit_pos,
	output reg tx_frame_start,
	input wire rx_system_clock,
	input wire rx_frame_pulse_in,
	input wire line_half_tick,
	input wire line_frame_start,
	input wire line_crc_mf_start,
	input wire line_sig_mf_start,
	input wire rx_line_data,
	input wire rx_line_sig,
	output reg [6:0] rx_line_slot,
	output reg [2:0] rx_line_bit,
	output reg rx_line_take,
	output reg rx_serial_data_out,
	output reg rx_serial_data_oe,
	output reg rx_signaling_out,
	output reg rx_signaling_oe,
	output reg rx_frame_pulse_out,
	output reg rx_frame_pulse_oe,
	output reg rx_clock_out,
	output reg rx_clock_oe
);

	// Registers
	reg [6:0] tx_slot_q;
	reg [3:0] tx_bit_q;
	reg [3:0] rx_opt_q;
	reg rx_sub_q;
	reg [3:0] rx_fp_q;
	reg [6:0] rx_slot_q;
	reg [1:0] mode_q;
	reg tx_locked_q;
	reg rx_locked_q;

	// Bus slave
	wire [9:0] idx = wb_adr_i[11:2];
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];
	reg [7:0] rd_d;

	always @* begin
		rd_d = 8'h00;
		if (idx == `E1BO_IDX_TX_SLOT) begin
			rd_d = {1'b0, tx_slot_q};
		end else if (idx == `E1BO_IDX_TX_BIT) begin
			rd_d = {4'h0, tx_bit_q};
		end else if (idx == `E1BO_IDX_RX_OPT) begin
			rd_d = {4'h0, rx_opt_q};
		end else if (idx == `E1BO_IDX_RX_SUB) begin
			rd_d = {7'h00, rx_sub_q};
		end else if (idx == `E1BO_IDX_RX_FP) begin
			rd_d = {3'h0, rx_fp_q, 1'b0};
		end else if (idx == `E1BO_IDX_RX_SLOT) begin
			rd_d = {1'b0, rx_slot_q};
		end else if (idx == `E1BO_IDX_MODE) begin
			rd_d = {6'h00, mode_q};
		end else if (idx == `E1BO_IDX_STATUS) begin
			rd_d = {6'h00, rx_locked_q, tx_locked_q};
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			tx_slot_q <= `E1BO_RST_TX_SLOT;
			tx_bit_q <= `E1BO_RST_TX_BIT;
			rx_opt_q <= `E1BO_RST_RX_OPT;
			rx_sub_q <= `E1BO_RST_RX_SUB;
			rx_fp_q <= `E1BO_RST_RX_FP;
			rx_slot_q <= `E1BO_RST_RX_SLOT;
			mode_q <= `E1BO_RST_MODE;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				wb_dat_o <= {24'h000000, rd_d};
			end
			if (bus_wr) begin
				if (idx == `E1BO_IDX_TX_SLOT) begin
					tx_slot_q <= wd[6:0];
				end else if (idx == `E1BO_IDX_TX_BIT) begin
					tx_bit_q <= wd[3:0];
				end else if (idx == `E1BO_IDX_RX_OPT) begin
					rx_opt_q <= wd[3:0];
				end else if (idx == `E1BO_IDX_RX_SUB) begin
					rx_sub_q <= wd[0];
				end else if (idx == `E1BO_IDX_RX_FP) begin
					rx_fp_q <= wd[4:1];
				end else if (idx == `E1BO_IDX_RX_SLOT) begin
					rx_slot_q <= wd[6:0];
				end else if (idx == `E1BO_IDX_MODE) begin
					mode_q <= wd[1:0];
				end
			end
		end
	end

	wire muxed = mode_q[`E1BO_MODE_MUX];
	wire [9:0] frame_mask = muxed ? `E1BO_LAST_BIT_MUX : `E1BO_LAST_BIT_NMUX;
	wire [6:0] slot_mask = muxed ? 7'h7F : `E1BO_SLOT_MASK_NMUX;

	// Pin synchronisers
	reg [2:0] tck_s;
	reg [1:0] tfp_s;
	reg [1:0] tdat_s;
	reg [1:0] tsig_s;
	reg [2:0] rck_s;
	reg [1:0] rfp_s;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_s <= 3'h0;
			tfp_s <= 2'h0;
			tdat_s <= 2'h0;
			tsig_s <= 2'h0;
			rck_s <= 3'h0;
			rfp_s <= 2'h0;
		end else begin
			tck_s <= {tck_s[1:0], tx_system_clock};
			tfp_s <= {tfp_s[0], tx_frame_pulse};
			tdat_s <= {tdat_s[0], tx_serial_data_in};
			tsig_s <= {tsig_s[0], tx_signaling_in};
			rck_s <= {rck_s[1:0], rx_system_clock};
			rfp_s <= {rfp_s[0], rx_frame_pulse_in};
		end
	end

	// Transmit: falling edge of the system clock is the active edge
	wire tx_edge = tck_s[2] & ~tck_s[1];
	wire tx_dbl = mode_q[`E1BO_MODE_TXDBL];
	reg tx_fp_prev_q;
	reg tx_half_q;
	reg [9:0] tx_cnt_q;
	wire tx_fp_new = tfp_s[1] & ~tx_fp_prev_q;
	wire tx_phase = tx_fp_new ? 1'b0 : tx_half_q;
	wire tx_take = ~tx_dbl | (tx_phase == tx_bit_q[`E1BO_TXB_EDGE]);
	wire [9:0] tx_cnt_d = tx_fp_new ? 10'h000 :
		((tx_cnt_q + `E1BO_POS_ONE) & frame_mask);
	// bit offset added to slot offset
	wire [9:0] tx_off = {(tx_slot_q & slot_mask), tx_bit_q[2:0]};
	wire [9:0] tx_pos = (tx_cnt_d - tx_off) & frame_mask;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_fp_prev_q <= 1'b0;
			tx_half_q <= 1'b0;
			tx_cnt_q <= 10'h000;
			tx_locked_q <= 1'b0;
			tx_bit_valid <= 1'b0;
			tx_bit_data <= 1'b0;
			tx_bit_sig <= 1'b0;
			tx_bit_slot <= 7'h00;
			tx_bit_pos <= 3'h0;
			tx_frame_start <= 1'b0;
		end else begin
			tx_bit_valid <= 1'b0;
			tx_frame_start <= 1'b0;
			if (tx_edge) begin
				tx_fp_prev_q <= tfp_s[1];
				tx_half_q <= tx_dbl ? ~tx_phase : 1'b0;
				if (tx_fp_new) begin
					tx_locked_q <= 1'b1;
				end
				// Pulse on an untaken edge: next taken bit is count 0
				if (tx_fp_new & ~tx_take) begin
					tx_cnt_q <= frame_mask;
				end
				if (tx_take) begin
					tx_cnt_q <= tx_cnt_d;
					tx_bit_valid <= 1'b1;
					tx_bit_data <= tdat_s[1];
					tx_bit_sig <= tsig_s[1];
					tx_bit_slot <= tx_pos[9:3];
					tx_bit_pos <= tx_pos[2:0];
					tx_frame_start <= (tx_pos == 10'h000);
				end
			end
		end
	end

	// Receive timing source
	// master uses line timing
	wire rx_master = ~rx_sub_q & ~muxed;
	wire [2:0] fpi = rx_fp_q[2:0];
	wire rx_inv = rx_fp_q[`E1BO_FP_INV];
	reg rck_int_q;
	wire rx_rise = rx_master ? (line_half_tick & ~rck_int_q) :
		(rck_s[1] & ~rck_s[2]);
	wire rx_fall = rx_master ? (line_half_tick & rck_int_q) :
		(rck_s[2] & ~rck_s[1]);
	wire rx_dev = rx_opt_q[`E1BO_RXO_DE] ? rx_rise : rx_fall;
	wire rx_fev = rx_opt_q[`E1BO_RXO_FE] ? rx_rise : rx_fall;
	// double rate only from system clock
	wire rx_dbl = rx_opt_q[`E1BO_RXO_CMS] & ~rx_master;
	reg rx_half_q;
	reg rx_pend_q;
	reg rx_fp_prev_q;
	reg rx_crc_q;
	reg rx_sig_q;
	reg [9:0] rx_cnt_q;
	wire rx_take = rx_dev & (~rx_dbl | ~rx_half_q);
	wire rx_fp_act = rfp_s[1] ^ rx_inv;
	wire rx_fp_new = rx_fev & rx_fp_act & ~rx_fp_prev_q;
	wire rx_no_off = rx_master & (fpi == `E1BO_FPI_OHD);
	wire [9:0] rx_off = rx_no_off ? 10'h000 :
		{(rx_slot_q & slot_mask), 3'h0};
	wire [9:0] rx_cnt_d = rx_pend_q ? 10'h000 :
		((rx_cnt_q + `E1BO_POS_ONE) & frame_mask);
	wire [9:0] rx_next = (rx_cnt_d - rx_off) & frame_mask;
	wire [4:0] rx_ts = rx_cnt_q[7:3];
	reg rx_fp_lvl;

	// Master pulse shape at the current frame position
	always @* begin
		rx_fp_lvl = 1'b0;
		case (fpi)
			`E1BO_FPI_CRC: rx_fp_lvl = (rx_cnt_q == 10'h000) & rx_crc_q;
			`E1BO_FPI_SIG: rx_fp_lvl = (rx_cnt_q == 10'h000) & rx_sig_q;
			`E1BO_FPI_BOTH: begin
				if ((rx_cnt_q == 10'h000) & rx_sig_q) begin
					rx_fp_lvl = 1'b1;
				end else if ((rx_cnt_q == `E1BO_POS_ONE) & rx_crc_q) begin
					rx_fp_lvl = 1'b0;
				end else begin
					rx_fp_lvl = rx_frame_pulse_out ^ rx_inv;
				end
			end
			`E1BO_FPI_OHD: rx_fp_lvl = (rx_ts == `E1BO_SLOT_TS0) |
				(rx_ts == `E1BO_SLOT_TS16);
			default: rx_fp_lvl = (rx_cnt_q == 10'h000);
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rck_int_q <= 1'b0;
			rx_half_q <= 1'b0;
			rx_pend_q <= 1'b0;
			rx_fp_prev_q <= 1'b0;
			rx_crc_q <= 1'b0;
			rx_sig_q <= 1'b0;
			rx_cnt_q <= 10'h000;
			rx_locked_q <= 1'b0;
			rx_line_slot <= 7'h00;
			rx_line_bit <= 3'h0;
			rx_line_take <= 1'b0;
			rx_serial_data_out <= 1'b0;
			rx_serial_data_oe <= 1'b0;
			rx_signaling_out <= 1'b0;
			rx_signaling_oe <= 1'b0;
			rx_frame_pulse_out <= 1'b0;
			rx_frame_pulse_oe <= 1'b0;
			rx_clock_out <= 1'b0;
			rx_clock_oe <= 1'b0;
		end else begin
			rx_line_take <= 1'b0;
			if (line_half_tick) begin
				rck_int_q <= ~rck_int_q;
			end
			rx_clock_out <= rck_int_q;
			rx_clock_oe <= rx_master;
			rx_frame_pulse_oe <= rx_master;
			rx_serial_data_oe <= ~rx_opt_q[`E1BO_RXO_TRI];
			rx_signaling_oe <= ~rx_opt_q[`E1BO_RXO_TRI];
			if (rx_master) begin
				if (line_frame_start) begin
					rx_pend_q <= 1'b1;
					rx_locked_q <= 1'b1;
					rx_crc_q <= line_crc_mf_start;
					rx_sig_q <= line_sig_mf_start;
				end
			end else if (rx_fev) begin
				rx_fp_prev_q <= rx_fp_act;
				if (rx_fp_new) begin
					rx_pend_q <= 1'b1;
					rx_locked_q <= 1'b1;
				end
			end
			if (rx_master & rx_fev) begin
				rx_frame_pulse_out <= rx_fp_lvl ^ rx_inv;
			end
			if (rx_dev & rx_dbl) begin
				rx_half_q <= rx_pend_q ? 1'b1 : ~rx_half_q;
			end
			// Next position is published ahead so the line side can stage it
			rx_line_slot <= rx_next[9:3];
			rx_line_bit <= rx_next[2:0];
			if (rx_take) begin
				rx_cnt_q <= rx_cnt_d;
				if (~(rx_master & line_frame_start)) begin
					rx_pend_q <= 1'b0;
				end
				rx_serial_data_out <= rx_line_data;
				rx_signaling_out <= rx_line_sig;
				rx_line_take <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

//--- hw/e1bo_defs.vh
// Constants for the E1 backplane offset and framing block
`ifndef E1BO_DEFS_VH
`define E1BO_DEFS_VH

// Register indices; the byte address is four times the index
`define E1BO_IDX_TX_SLOT 10'h044
`define E1BO_IDX_TX_BIT 10'h045
`define E1BO_IDX_RX_OPT 10'h046
`define E1BO_IDX_RX_SUB 10'h047
`define E1BO_IDX_RX_FP 10'h048
`define E1BO_IDX_RX_SLOT 10'h049
`define E1BO_IDX_MODE 10'h060
`define E1BO_IDX_STATUS 10'h061

// Reset values
`define E1BO_RST_TX_SLOT 7'h00
`define E1BO_RST_TX_BIT 4'h0
`define E1BO_RST_RX_OPT 4'hD
`define E1BO_RST_RX_SUB 1'h1
`define E1BO_RST_RX_FP 4'h0
`define E1BO_RST_RX_SLOT 7'h00
`define E1BO_RST_MODE 2'h0

// Field positions
`define E1BO_TXB_EDGE 3
`define E1BO_RXO_DE 3
`define E1BO_RXO_FE 2
`define E1BO_RXO_CMS 1
`define E1BO_RXO_TRI 0
`define E1BO_FP_INV 3
`define E1BO_MODE_TXDBL 0
`define E1BO_MODE_MUX 1

// Frame pulse indication codes
`define E1BO_FPI_BASIC 3'h0
`define E1BO_FPI_CRC 3'h1
`define E1BO_FPI_SIG 3'h2
`define E1BO_FPI_BOTH 3'h3
`define E1BO_FPI_OHD 3'h4

// Frame geometry in bits, minus one, and slot limits
`define E1BO_LAST_BIT_NMUX 10'h0FF
`define E1BO_LAST_BIT_MUX 10'h3FF
`define E1BO_SLOT_MASK_NMUX 7'h1F
`define E1BO_SLOT_TS0 5'h00
`define E1BO_SLOT_TS16 5'h10
`define E1BO_POS_ONE 10'h001

`endif
